// >>> verilog/cpu_regs_pkg.sv
// Shared constants, flag layout and command codes of the CPU core register set.
package cpu_regs_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int CORE_REG_COUNT = 6;

  // Flag bit positions inside the flags register.
  localparam int FLAG_HALF = 4;
  localparam int FLAG_MASK = 3;
  localparam int FLAG_SIGN = 2;
  localparam int FLAG_ZERO = 1;
  localparam int FLAG_CARRY = 0;
  localparam int RESULT_SIGN_BIT = 7;

  // Reset values; the undefined flag bits come up as zero.
  localparam logic [7:0] FLAGS_RESET = 8'hE8;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'hE0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic [15:0] POINTER_STEP = 16'h0001;

  // Stack: upper byte fixed by hardware, low byte resets to the top of the stack.
  localparam logic [7:0] STACK_FIXED_HIGH = 8'h01;
  localparam logic [7:0] STACK_RESET_LOW = 8'hFF;

  // Sequence step counts: interrupt context is five bytes, a single pop is one.
  localparam logic [2:0] STEP_FIRST = 3'h0;
  localparam logic [2:0] STEP_ONE = 3'h1;
  localparam logic [2:0] CONTEXT_LAST = 3'h4;
  localparam logic [2:0] SINGLE_LAST = 3'h0;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_WRITE = 4'h1,
    CMD_ALU = 4'h2,
    SET_MASK_OP = 4'h3,
    CLEAR_MASK_OP = 4'h4,
    CMD_SET_CARRY = 4'h5,
    CMD_CLEAR_CARRY = 4'h6,
    CMD_PUSH = 4'h7,
    CMD_POP = 4'h8,
    CMD_RESET_SP = 4'h9,
    CMD_JUMP = 4'hA,
    RETURN_FROM_HANDLER = 4'hB
  } cmd_t;

  typedef enum logic [2:0] {
    SEL_ACC = 3'h0,
    SEL_INDEX_ONE = 3'h1,
    SEL_INDEX_TWO = 3'h2,
    SEL_POINTER_LOW_BYTE = 3'h3,
    SEL_POINTER_LOW_BYTE_UPPER = 3'h4,
    SEL_FLAGS = 3'h5,
    SEL_STACK_LOW = 3'h6
  } regSel_t;

  typedef enum logic [2:0] {
    TEST_HALF = 3'h0,
    TEST_MASK = 3'h1,
    TEST_SIGN = 3'h2,
    TEST_ZERO = 3'h3,
    TEST_CARRY = 3'h4
  } flagSel_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PUSH = 4'h2,
    ST_POP = 4'h4,
    ST_DRAIN = 4'h8
  } seqState_t;

endpackage

// >>> verilog/flag_unit.sv
// Next-value logic of the flags register.
module flag_unit (
  input wire logic [7:0] flagsCur,
  input wire logic loadAll,
  input wire logic [7:0] loadVal,
  input wire logic updNZ,
  input wire logic [7:0] result,
  input wire logic updC,
  input wire logic carryIn,
  input wire logic updH,
  input wire logic halfIn,
  input wire logic setMask,
  input wire logic clearMask,
  input wire logic setCarry,
  input wire logic clearCarry,
  output logic [7:0] flagsNext
);

  // A whole-register load wins; otherwise each flag follows its own update.
  always_comb begin
    flagsNext = flagsCur;
    if (loadAll) begin
      flagsNext = loadVal;  // see [RL7]
    end else begin
      if (updNZ) begin
        flagsNext[cpu_regs_pkg::FLAG_SIGN] = result[cpu_regs_pkg::RESULT_SIGN_BIT];  // see [RL14]
        flagsNext[cpu_regs_pkg::FLAG_ZERO] = (result == cpu_regs_pkg::DATA_ZERO);  // see [RL15]
      end
      if (updH) begin
        flagsNext[cpu_regs_pkg::FLAG_HALF] = halfIn;  // see [RL8]
      end
      if (updC) begin
        flagsNext[cpu_regs_pkg::FLAG_CARRY] = carryIn;  // see [RL16]
      end else if (setCarry) begin
        flagsNext[cpu_regs_pkg::FLAG_CARRY] = 1'b1;  // see [RL16]
      end else if (clearCarry) begin
        flagsNext[cpu_regs_pkg::FLAG_CARRY] = 1'b0;  // see [RL16]
      end
      if (setMask) begin
        flagsNext[cpu_regs_pkg::FLAG_MASK] = 1'b1;  // see [RL10]
      end else if (clearMask) begin
        flagsNext[cpu_regs_pkg::FLAG_MASK] = 1'b0;  // see [RL11]
      end
    end
    // The top three bits are wired high, so no load can clear them.
    flagsNext = flagsNext | cpu_regs_pkg::FLAGS_FIXED_ONES;  // see [RL18]
  end

endmodule

// >>> verilog/stack_pointer.sv
// Stack pointer low byte with fixed high byte and silent wrap.
module stack_pointer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic resetPtr,
  input wire logic loadPtr,
  input wire logic [7:0] loadVal,
  input wire logic decPtr,
  input wire logic incPtr,
  output logic [7:0] ptrLow
);

  logic [7:0] ptrLow_reg;
  logic [7:0] ptrLow_next;

  // Plain 8-bit arithmetic wraps at both stack limits without any warning.
  assign ptrLow_next = resetPtr ? cpu_regs_pkg::STACK_RESET_LOW :
                       loadPtr ? loadVal :
                       decPtr ? ptrLow_reg - cpu_regs_pkg::BYTE_ONE :
                       incPtr ? ptrLow_reg + cpu_regs_pkg::BYTE_ONE :
                       ptrLow_reg;  // see [RL17]

  // Synchronous reset puts the pointer on the stack's upper limit.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ptrLow_reg <= cpu_regs_pkg::STACK_RESET_LOW;
    end else begin
      ptrLow_reg <= ptrLow_next;
    end
  end

  assign ptrLow = ptrLow_reg;

endmodule

// >>> verilog/cpu_core_register_set.sv
// Programmer-visible register set of the 8-bit CPU core with interrupt context handling.

// Contract
// [RL1] Six core registers, reached by commands only.
// [RL2] Eight-bit accumulator for operands and results.
// [RL3] Two eight-bit index registers, addressing or storage.
// [RL4] Second index never saved on interrupt context.
// [RL5] Sixteen-bit instruction pointer with separate byte halves.
// [RL6] Flags register, top three ones, reset 111x1xxx.
// [RL7] Whole flags push/pop; individual flags tested.
// [RL8] Add sets nibble carry from bit three.
// [RL9] Branch tests nibble carry set and clear.
// [RL10] Mask set on interrupt entry or software.
// [RL11] Mask cleared only by software commands.
// [RL12] Masked interrupt requests stay pending, taken later.
// [RL13] Handler return restores mask; pending then taken.
// [RL14] Sign flag copies result bit seven.
// [RL15] Zero flag marks a null result.
// [RL16] Carry from arithmetic, shifts, set and reset.
// [RL17] Stack pointer fixed high byte, wraps silently.
// [RL18] Flags top bits ignore writes, read one.
module cpu_core_register_set (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cpu_regs_pkg::cmd_t cmd,
  input wire cpu_regs_pkg::regSel_t regSel,
  input wire logic [7:0] dataIn,
  input wire logic [15:0] addrIn,
  input wire logic pcStep,
  input wire logic updNZ,
  input wire logic updC,
  input wire logic carryIn,
  input wire logic updH,
  input wire logic halfIn,
  input wire cpu_regs_pkg::flagSel_t testSel,
  input wire logic testPolarity,
  input wire logic instrBoundary,
  input wire logic irqEvent,
  input wire logic trapEvent,
  input wire logic [15:0] irqVector,
  input wire logic [7:0] stackRdData,
  output logic [7:0] accumulator,
  output logic [7:0] indexOne,
  output logic [7:0] indexTwo,
  output logic [15:0] nextInstrPointer,
  output logic [7:0] flags,
  output logic [15:0] stackPtr,
  output logic [15:0] stackAddr,
  output logic [7:0] stackWrData,
  output logic stackWrEn,
  output logic stackRdEn,
  output logic busy,
  output logic irqEntry,
  output logic irqPending,
  output logic branchTrue
);

  // Byte that a register selection reads.
  function automatic logic [7:0] selByte(input cpu_regs_pkg::regSel_t sel,
                                         input logic [7:0] a, input logic [7:0] x,
                                         input logic [7:0] y, input logic [15:0] pc,
                                         input logic [7:0] cc, input logic [7:0] sp);
    logic [7:0] value;
    value = cpu_regs_pkg::DATA_ZERO;
    case (sel)
      cpu_regs_pkg::SEL_ACC: value = a;
      cpu_regs_pkg::SEL_INDEX_ONE: value = x;
      cpu_regs_pkg::SEL_INDEX_TWO: value = y;
      cpu_regs_pkg::SEL_POINTER_LOW_BYTE: value = pc[7:0];
      cpu_regs_pkg::SEL_POINTER_LOW_BYTE_UPPER: value = pc[15:8];
      cpu_regs_pkg::SEL_FLAGS: value = cc;
      cpu_regs_pkg::SEL_STACK_LOW: value = sp;
      default: value = cpu_regs_pkg::DATA_ZERO;
    endcase
    return value;
  endfunction

  // Context push order; the second index has no slot at all.
  function automatic cpu_regs_pkg::regSel_t entrySel(input logic [2:0] step);
    cpu_regs_pkg::regSel_t sel;
    sel = cpu_regs_pkg::SEL_FLAGS;
    case (step)
      3'h0: sel = cpu_regs_pkg::SEL_POINTER_LOW_BYTE;
      3'h1: sel = cpu_regs_pkg::SEL_POINTER_LOW_BYTE_UPPER;
      3'h2: sel = cpu_regs_pkg::SEL_INDEX_ONE;
      3'h3: sel = cpu_regs_pkg::SEL_ACC;
      default: sel = cpu_regs_pkg::SEL_FLAGS;
    endcase
    return sel;  // see [RL4]
  endfunction

  // Context pop order is the push order reversed.
  function automatic cpu_regs_pkg::regSel_t returnSel(input logic [2:0] idx);
    cpu_regs_pkg::regSel_t sel;
    sel = cpu_regs_pkg::SEL_POINTER_LOW_BYTE;
    case (idx)
      3'h0: sel = cpu_regs_pkg::SEL_FLAGS;
      3'h1: sel = cpu_regs_pkg::SEL_ACC;
      3'h2: sel = cpu_regs_pkg::SEL_INDEX_ONE;
      3'h3: sel = cpu_regs_pkg::SEL_POINTER_LOW_BYTE_UPPER;
      default: sel = cpu_regs_pkg::SEL_POINTER_LOW_BYTE;
    endcase
    return sel;  // see [RL4]
  endfunction

  logic [7:0] accumulator_reg;
  logic [7:0] indexOne_reg;
  logic [7:0] indexTwo_reg;
  logic [15:0] pointer_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  cpu_regs_pkg::seqState_t state_reg;
  cpu_regs_pkg::seqState_t state_next;
  logic [2:0] step_reg;
  logic [2:0] step_next;
  logic [2:0] lastStep_reg;
  logic isReturn_reg;
  cpu_regs_pkg::regSel_t popDest_reg;
  logic [2:0] readIdx_reg;
  logic pend_reg;
  logic [2:0] pendIdx_reg;
  logic irqPending_reg;
  logic trapPending_reg;
  logic irqEntry_reg;
  logic busy_reg;
  logic branchTrue_reg;
  logic [15:0] stackAddr_reg;
  logic [7:0] stackWrData_reg;
  logic stackWrEn_reg;
  logic stackRdEn_reg;
  logic [7:0] spLow;
  logic [7:0] spLowPlus;

  // Interrupt acceptance: the trap ignores the mask, maskable requests wait for it.
  wire idle = (state_reg == cpu_regs_pkg::ST_IDLE);
  wire maskSet = flags_reg[cpu_regs_pkg::FLAG_MASK];
  wire takeTrap = idle && instrBoundary && trapPending_reg;  // see [RL10]
  wire takeIrq = idle && instrBoundary && irqPending_reg && !maskSet && !takeTrap;  // see [RL12]
  wire entryStart = takeTrap || takeIrq;

  // Commands act only in idle cycles; a command beside an accepted interrupt is dropped.
  wire cmdActive = idle && !entryStart;
  wire cmdWrite = cmdActive && (cmd == cpu_regs_pkg::CMD_WRITE || cmd == cpu_regs_pkg::CMD_ALU);
  wire cmdAlu = cmdActive && (cmd == cpu_regs_pkg::CMD_ALU);
  wire cmdPush = cmdActive && (cmd == cpu_regs_pkg::CMD_PUSH);
  wire cmdPop = cmdActive && (cmd == cpu_regs_pkg::CMD_POP);
  wire cmdReturn = cmdActive && (cmd == cpu_regs_pkg::RETURN_FROM_HANDLER);
  wire cmdJump = cmdActive && (cmd == cpu_regs_pkg::CMD_JUMP);

  // Stack traffic of the sequencer and of single push commands.
  wire inPush = (state_reg == cpu_regs_pkg::ST_PUSH);
  wire entryDone = inPush && (step_reg == cpu_regs_pkg::CONTEXT_LAST);
  wire pushNow = inPush || cmdPush;
  wire popIssue = (state_reg == cpu_regs_pkg::ST_POP);
  wire cpu_regs_pkg::regSel_t pushSel = inPush ? entrySel(step_reg) : regSel;
  wire [7:0] pushData = selByte(pushSel, accumulator_reg, indexOne_reg, indexTwo_reg,
                                pointer_reg, flags_reg, spLow);  // see [RL7]
  assign spLowPlus = spLow + cpu_regs_pkg::BYTE_ONE;

  // One write path into the registers: popped bytes while busy, commands when idle.
  wire wrEn = pend_reg || cmdWrite;  // see [RL1]
  wire cpu_regs_pkg::regSel_t wrSel = pend_reg ?
      (isReturn_reg ? returnSel(pendIdx_reg) : popDest_reg) : regSel;
  wire [7:0] wrData = pend_reg ? stackRdData : dataIn;
  wire lastCapture = pend_reg && (pendIdx_reg == lastStep_reg);

  // Per-register next values.
  wire [7:0] accumulator_next = (wrEn && wrSel == cpu_regs_pkg::SEL_ACC) ?
      wrData : accumulator_reg;  // see [RL2]
  wire [7:0] indexOne_next = (wrEn && wrSel == cpu_regs_pkg::SEL_INDEX_ONE) ?
      wrData : indexOne_reg;  // see [RL3]
  wire [7:0] indexTwo_next = (wrEn && wrSel == cpu_regs_pkg::SEL_INDEX_TWO) ?
      wrData : indexTwo_reg;  // see [RL3]
  wire [7:0] pointerLowByte = (wrEn && wrSel == cpu_regs_pkg::SEL_POINTER_LOW_BYTE) ?
      wrData : pointer_reg[7:0];  // see [RL5]
  wire [7:0] pointerLowByteUpper = (wrEn && wrSel == cpu_regs_pkg::SEL_POINTER_LOW_BYTE_UPPER) ?
      wrData : pointer_reg[15:8];  // see [RL5]
  wire [15:0] pointerStepped = pointer_reg + cpu_regs_pkg::POINTER_STEP;
  wire [15:0] pointer_next = entryDone ? irqVector :
                             cmdJump ? addrIn :
                             (cmdActive && pcStep) ? pointerStepped :
                             {pointerLowByteUpper, pointerLowByte};  // see [RL5]

  // Branch tests read the flag that the selection names.
  wire testedFlag = (testSel == cpu_regs_pkg::TEST_HALF) ? flags_reg[cpu_regs_pkg::FLAG_HALF] :
                    (testSel == cpu_regs_pkg::TEST_MASK) ? flags_reg[cpu_regs_pkg::FLAG_MASK] :
                    (testSel == cpu_regs_pkg::TEST_SIGN) ? flags_reg[cpu_regs_pkg::FLAG_SIGN] :
                    (testSel == cpu_regs_pkg::TEST_ZERO) ? flags_reg[cpu_regs_pkg::FLAG_ZERO] :
                    flags_reg[cpu_regs_pkg::FLAG_CARRY];  // see [RL9]

  flag_unit flagLogic (
    .flagsCur(flags_reg),
    .loadAll(wrEn && wrSel == cpu_regs_pkg::SEL_FLAGS),
    .loadVal(wrData),
    .updNZ(cmdAlu && updNZ),
    .result(dataIn),
    .updC(cmdAlu && updC),
    .carryIn(carryIn),
    .updH(cmdAlu && updH),
    .halfIn(halfIn),
    .setMask(entryDone || (cmdActive && cmd == cpu_regs_pkg::SET_MASK_OP)),
    .clearMask(cmdActive && cmd == cpu_regs_pkg::CLEAR_MASK_OP),
    .setCarry(cmdActive && cmd == cpu_regs_pkg::CMD_SET_CARRY),
    .clearCarry(cmdActive && cmd == cpu_regs_pkg::CMD_CLEAR_CARRY),
    .flagsNext(flags_next)
  );  // see [RL10] see [RL11] see [RL13]

  stack_pointer stackLogic (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .resetPtr(cmdActive && cmd == cpu_regs_pkg::CMD_RESET_SP),
    .loadPtr(wrEn && wrSel == cpu_regs_pkg::SEL_STACK_LOW),
    .loadVal(wrData),
    .decPtr(pushNow),
    .incPtr(popIssue),
    .ptrLow(spLow)
  );  // see [RL17]

  // Sequencer: context push back to idle, or reads issued back to back, then drain of the last byte.
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    case (state_reg)
      cpu_regs_pkg::ST_IDLE: begin
        step_next = cpu_regs_pkg::STEP_FIRST;
        if (entryStart) begin
          state_next = cpu_regs_pkg::ST_PUSH;
        end else if (cmdPop || cmdReturn) begin
          state_next = cpu_regs_pkg::ST_POP;
        end
      end
      cpu_regs_pkg::ST_PUSH: begin
        step_next = step_reg + cpu_regs_pkg::STEP_ONE;
        if (entryDone) begin
          state_next = cpu_regs_pkg::ST_IDLE;
        end
      end
      cpu_regs_pkg::ST_POP: begin
        step_next = step_reg + cpu_regs_pkg::STEP_ONE;
        if (step_reg == lastStep_reg) begin
          state_next = cpu_regs_pkg::ST_DRAIN;
        end
      end
      cpu_regs_pkg::ST_DRAIN: begin
        if (lastCapture) begin
          state_next = cpu_regs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = cpu_regs_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and the pop bookkeeping.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= cpu_regs_pkg::ST_IDLE;
      step_reg <= cpu_regs_pkg::STEP_FIRST;
      lastStep_reg <= cpu_regs_pkg::SINGLE_LAST;
      isReturn_reg <= 1'b0;
      popDest_reg <= cpu_regs_pkg::SEL_ACC;
      readIdx_reg <= cpu_regs_pkg::STEP_FIRST;
      pend_reg <= 1'b0;
      pendIdx_reg <= cpu_regs_pkg::STEP_FIRST;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      if (cmdPop || cmdReturn) begin
        lastStep_reg <= cmdReturn ? cpu_regs_pkg::CONTEXT_LAST : cpu_regs_pkg::SINGLE_LAST;
        isReturn_reg <= cmdReturn;  // see [RL13]
        popDest_reg <= regSel;
      end
      readIdx_reg <= step_reg;
      pend_reg <= stackRdEn_reg;
      pendIdx_reg <= readIdx_reg;
    end
  end

  // Pending requests: a new event in the taking cycle re-arms the latch.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irqPending_reg <= 1'b0;
      trapPending_reg <= 1'b0;
      irqEntry_reg <= 1'b0;
    end else begin
      irqPending_reg <= irqEvent || (irqPending_reg && !takeIrq);  // see [RL12]
      trapPending_reg <= trapEvent || (trapPending_reg && !takeTrap);
      irqEntry_reg <= entryStart;
    end
  end

  // Core registers; the flags come up with the mask set.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      accumulator_reg <= cpu_regs_pkg::DATA_RESET;
      indexOne_reg <= cpu_regs_pkg::DATA_RESET;
      indexTwo_reg <= cpu_regs_pkg::DATA_RESET;
      pointer_reg <= cpu_regs_pkg::POINTER_RESET;
      flags_reg <= cpu_regs_pkg::FLAGS_RESET;  // see [RL6]
    end else begin
      accumulator_reg <= accumulator_next;
      indexOne_reg <= indexOne_next;
      indexTwo_reg <= indexTwo_next;
      pointer_reg <= pointer_next;
      flags_reg <= flags_next;  // see [RL6]
    end
  end

  // Stack port: push writes at the pointer, pop reads at the pointer plus one.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stackAddr_reg <= {cpu_regs_pkg::STACK_FIXED_HIGH, cpu_regs_pkg::STACK_RESET_LOW};
      stackWrData_reg <= cpu_regs_pkg::DATA_ZERO;
      stackWrEn_reg <= 1'b0;
      stackRdEn_reg <= 1'b0;
    end else begin
      stackAddr_reg <= {cpu_regs_pkg::STACK_FIXED_HIGH, pushNow ? spLow : spLowPlus};  // see [RL17]
      stackWrData_reg <= pushData;
      stackWrEn_reg <= pushNow;
      stackRdEn_reg <= popIssue;
    end
  end

  // Status toward the decoder, all registered.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      branchTrue_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next != cpu_regs_pkg::ST_IDLE);
      branchTrue_reg <= (testedFlag == testPolarity);  // see [RL9]
    end
  end

  assign accumulator = accumulator_reg;
  assign indexOne = indexOne_reg;
  assign indexTwo = indexTwo_reg;
  assign nextInstrPointer = pointer_reg;
  assign flags = flags_reg;
  assign stackPtr = {cpu_regs_pkg::STACK_FIXED_HIGH, spLow};
  assign stackAddr = stackAddr_reg;
  assign stackWrData = stackWrData_reg;
  assign stackWrEn = stackWrEn_reg;
  assign stackRdEn = stackRdEn_reg;
  assign busy = busy_reg;
  assign irqEntry = irqEntry_reg;
  assign irqPending = irqPending_reg;
  assign branchTrue = branchTrue_reg;

endmodule

// >>> bench/cpu_core_register_set_asserts.sv
// Concurrent checks tied to the ports of the CPU core register set.
module cpu_core_register_set_asserts (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cpu_regs_pkg::cmd_t cmd,
  input wire logic [7:0] dataIn,
  input wire logic updNZ,
  input wire logic updH,
  input wire logic halfIn,
  input wire logic instrBoundary,
  input wire logic irqEvent,
  input wire logic [7:0] indexTwo,
  input wire logic [7:0] flags,
  input wire logic [15:0] stackPtr,
  input wire logic stackWrEn,
  input wire logic busy,
  input wire logic irqEntry,
  input wire logic irqPending
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Five context bytes written back to back, then none.
  sequence s_ctx_push;
    stackWrEn [*5] ##1 !stackWrEn;
  endsequence
  // A result counts only when idle and off a boundary cycle.
  sequence s_alu_taken;
    cmd == cpu_regs_pkg::CMD_ALU && !busy && !instrBoundary;
  endsequence
  // Properties on flags, stack and interrupt entry.
  property p_fixed_ones;
    flags[7:5] == 3'h7;
  endproperty
  property p_stack_high;
    stackPtr[15:8] == 8'h01;
  endproperty
  property p_entry_push;
    irqEntry |=> s_ctx_push;
  endproperty
  property p_entry_mask;
    irqEntry |-> busy [*5] ##1 (!busy && flags[cpu_regs_pkg::FLAG_MASK]);
  endproperty
  property p_idx2_kept;
    irqEntry |=> $stable(indexTwo) [*5];
  endproperty
  property p_mask_sw;
    $fell(flags[cpu_regs_pkg::FLAG_MASK]) |-> $past(busy) ||
      $past(cmd) inside {cpu_regs_pkg::CLEAR_MASK_OP, cpu_regs_pkg::CMD_WRITE};
  endproperty
  property p_alu_nz;
    s_alu_taken ##0 updNZ |=> flags[cpu_regs_pkg::FLAG_SIGN] == $past(dataIn[7]) &&
      flags[cpu_regs_pkg::FLAG_ZERO] == ($past(dataIn) == 8'h00);
  endproperty
  property p_half;
    s_alu_taken ##0 updH |=> flags[cpu_regs_pkg::FLAG_HALF] == $past(halfIn);
  endproperty
  property p_pending;
    irqEvent |=> irqPending;
  endproperty
  // One label per property.
  a_fixed_ones: assert property (p_fixed_ones) else $error("flags top bits not one");
  a_stack_high: assert property (p_stack_high) else $error("stack high byte moved");
  a_entry_push: assert property (p_entry_push) else $error("context push count");
  a_entry_mask: assert property (p_entry_mask) else $error("mask not set on entry");
  a_idx2_kept: assert property (p_idx2_kept) else $error("index two disturbed");
  a_mask_sw: assert property (p_mask_sw) else $error("mask cleared by hardware");
  a_alu_nz: assert property (p_alu_nz) else $error("sign or zero flag");
  a_half: assert property (p_half) else $error("nibble carry flag wrong");
  a_pending: assert property (p_pending) else $error("request not latched");
endmodule

// >>> bench/cpu_core_register_set_test.sv
// Self-checking testbench of the CPU core register set, with its stack memory.
module cpu_core_register_set_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic nrst = 1'b0;
  cpu_regs_pkg::cmd_t cmd = cpu_regs_pkg::CMD_NONE;
  cpu_regs_pkg::regSel_t regSel = cpu_regs_pkg::SEL_ACC;
  cpu_regs_pkg::flagSel_t testSel = cpu_regs_pkg::TEST_HALF;
  logic [7:0] dataIn = 8'h00, stackRdData = 8'h00;
  logic [15:0] addrIn = 16'h2468, irqVector = 16'hABCD;
  logic pcStep = 1'b0, updNZ = 1'b1, updC = 1'b1, carryIn = 1'b1, updH = 1'b1;
  logic halfIn = 1'b1, testPolarity = 1'b0, instrBoundary = 1'b0;
  logic irqEvent = 1'b0, trapEvent = 1'b0;
  logic [7:0] accumulator, indexOne, indexTwo, flags, stackWrData;
  logic [15:0] nextInstrPointer, stackPtr, stackAddr;
  logic stackWrEn, stackRdEn, busy, irqEntry, irqPending, branchTrue;
  logic [7:0] mem [256];
  logic [7:0] brPat = 8'hEA;
  logic [7:0] fexp [4] = '{8'hE8, 8'hE9, 8'hE1, 8'hE0};
  logic [7:0] ctx [5] = '{8'h35, 8'h12, 8'hC3, 8'h3C, 8'hE0};
  cpu_regs_pkg::cmd_t fcmd [4] = '{cpu_regs_pkg::SET_MASK_OP, cpu_regs_pkg::CMD_SET_CARRY,
    cpu_regs_pkg::CLEAR_MASK_OP, cpu_regs_pkg::CMD_CLEAR_CARRY};
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  cpu_core_register_set dut_u (.sys_clk, .nrst, .cmd, .regSel, .dataIn, .addrIn, .pcStep,
    .updNZ, .updC, .carryIn, .updH, .halfIn, .testSel, .testPolarity, .instrBoundary,
    .irqEvent, .trapEvent, .irqVector, .stackRdData, .accumulator, .indexOne, .indexTwo,
    .nextInstrPointer, .flags, .stackPtr, .stackAddr, .stackWrData, .stackWrEn, .stackRdEn,
    .busy, .irqEntry, .irqPending, .branchTrue);

  // The clock runs at 25 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Stack memory; idle read data is scrambled so stale bytes cannot pass.
  always @(posedge sys_clk) begin
    if (stackWrEn)
      mem[stackAddr[7:0]] <= stackWrData;
    stackRdData <= stackRdEn ? mem[stackAddr[7:0]] : ~stackRdData;
  end

  // A hang is cut short well after the sequence should have ended.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  // One command held for one cycle; the extra edge keeps commands apart.
  task automatic issue(input cpu_regs_pkg::cmd_t c, input logic [2:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    cmd <= c;
    regSel <= cpu_regs_pkg::regSel_t'(s);
    dataIn <= d;
    @(posedge sys_clk);
    cmd <= cpu_regs_pkg::CMD_NONE;
    #1;
  endtask

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    issue(cpu_regs_pkg::CMD_WRITE, s, d);
  endtask

  task automatic wait_idle();
    int n = 0;
    chk("busy", 16'h0001, 16'(busy));
    while (busy !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("busy", 16'h0000, 16'(busy));
  endtask

  task automatic pulse(input logic trap);
    @(posedge sys_clk);
    irqEvent <= !trap;
    trapEvent <= trap;
    @(posedge sys_clk);
    irqEvent <= 1'b0;
    trapEvent <= 1'b0;
    #1;
  endtask

  // One boundary cycle; an accepted interrupt runs its context push to the end.
  task automatic boundary(input logic expEntry);
    @(posedge sys_clk);
    instrBoundary <= 1'b1;
    @(posedge sys_clk);
    instrBoundary <= 1'b0;
    #1;
    chk("irqEntry", 16'(expEntry), 16'(irqEntry));
    if (expEntry)
      wait_idle();
  endtask

  // The main sequence.
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk("flags", 16'h00E8, 16'(flags));
    chk("stackPtr", 16'h01FF, stackPtr);
    wr(3'h0, 8'h3C);
    wr(3'h1, 8'hC3);
    wr(3'h2, 8'h77);
    wr(3'h3, 8'h34);
    wr(3'h4, 8'h12);
    chk("acc", 16'h003C, 16'(accumulator));
    chk("indexOne", 16'h00C3, 16'(indexOne));
    chk("indexTwo", 16'h0077, 16'(indexTwo));
    chk("pointer", 16'h1234, nextInstrPointer);
    @(posedge sys_clk);
    pcStep <= 1'b1;
    @(posedge sys_clk);
    pcStep <= 1'b0;
    #1;
    chk("pointer", 16'h1235, nextInstrPointer);
    wr(3'h5, 8'h00);
    chk("flags", 16'h00E0, 16'(flags));
    foreach (fcmd[i]) begin
      issue(fcmd[i], 3'h0, 8'h00);
      chk("flags", 16'(fexp[i]), 16'(flags));
    end
    issue(cpu_regs_pkg::CMD_ALU, 3'h0, 8'h80);
    chk("flags", 16'h00F5, 16'(flags));
    carryIn <= 1'b0;
    halfIn <= 1'b0;
    issue(cpu_regs_pkg::CMD_ALU, 3'h0, 8'h00);
    chk("flags", 16'h00E2, 16'(flags));
    wr(3'h5, 8'h0A);
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      testSel <= cpu_regs_pkg::flagSel_t'(i / 2);
      testPolarity <= i[0];
      @(posedge sys_clk);
      #1;
      chk("branchTrue", 16'(brPat[4 - i / 2] == i[0]), 16'(branchTrue));
    end
    // Pop on an empty stack wraps low; the push wraps back.
    mem[8'h00] = 8'h17;
    issue(cpu_regs_pkg::CMD_POP, 3'h5, 8'h00);
    wait_idle();
    chk("flags", 16'h00F7, 16'(flags));
    chk("stackPtr", 16'h0100, stackPtr);
    issue(cpu_regs_pkg::CMD_PUSH, 3'h0, 8'h00);
    chk("stackPtr", 16'h01FF, stackPtr);
    @(posedge sys_clk);
    #1;
    chk("pushed", 16'h0000, 16'(mem[8'h00]));
    wr(3'h0, 8'h3C);
    wr(3'h5, 8'h08);
    pulse(1'b0);
    chk("irqPending", 16'h0001, 16'(irqPending));
    boundary(1'b0);
    issue(cpu_regs_pkg::CLEAR_MASK_OP, 3'h0, 8'h00);
    boundary(1'b1);
    chk("flags", 16'h00E8, 16'(flags));
    chk("pointer", 16'hABCD, nextInstrPointer);
    chk("stackPtr", 16'h01FA, stackPtr);
    chk("irqPending", 16'h0000, 16'(irqPending));
    @(posedge sys_clk);
    #1;
    foreach (ctx[i])
      chk("context", 16'(ctx[i]), 16'(mem[8'hFF - i]));
    wr(3'h2, 8'h11);
    wr(3'h0, 8'h99);
    pulse(1'b0);
    boundary(1'b0);
    issue(cpu_regs_pkg::RETURN_FROM_HANDLER, 3'h0, 8'h00);
    wait_idle();
    chk("flags", 16'h00E0, 16'(flags));
    chk("acc", 16'h003C, 16'(accumulator));
    chk("indexTwo", 16'h0011, 16'(indexTwo));
    chk("pointer", 16'h1235, nextInstrPointer);
    chk("stackPtr", 16'h01FF, stackPtr);
    boundary(1'b1);
    pulse(1'b1);
    boundary(1'b1);
    issue(cpu_regs_pkg::CMD_JUMP, 3'h0, 8'h00);
    chk("pointer", 16'h2468, nextInstrPointer);
    wr(3'h6, 8'h80);
    chk("stackPtr", 16'h0180, stackPtr);
    issue(cpu_regs_pkg::CMD_RESET_SP, 3'h0, 8'h00);
    chk("stackPtr", 16'h01FF, stackPtr);
    tally_and_finish();
  end
endmodule

bind cpu_core_register_set cpu_core_register_set_asserts chk_u (.sys_clk, .nrst, .cmd,
  .dataIn, .updNZ, .updH, .halfIn, .instrBoundary, .irqEvent, .indexTwo, .flags, .stackPtr,
  .stackWrEn, .busy, .irqEntry, .irqPending);
